// ==== include/dsc_pkg.sv ====
package dsc_pkg;
  // Register indices as printed; one index addresses one 16-bit word.
  localparam logic [15:0] ADDR_REF_A = 16'h0001;
  localparam logic [15:0] ADDR_REF_B = 16'h0002;
  localparam logic [15:0] ADDR_DRIVE_STATE = 16'h002c;
  localparam logic [15:0] ADDR_RELAY_STATE = 16'h002d;
  localparam logic [15:0] ADDR_DC_BUS = 16'h0031;
  localparam logic [15:0] ADDR_TORQUE = 16'h0032;
  localparam logic [15:0] ADDR_POWER = 16'h0033;
  localparam logic [15:0] ADDR_CPU_FW = 16'h003b;
  localparam logic [15:0] ADDR_FLASH_FW = 16'h003c;
  localparam logic [15:0] ADDR_LINK_ERR = 16'h003d;
  localparam logic [15:0] ADDR_POWER_RATING = 16'h003e;
  localparam logic [15:0] ADDR_CTRL_METHOD = 16'h003f;
  localparam logic [15:0] ADDR_FAULT_NOW = 16'h0080;
  localparam logic [15:0] ADDR_FAULT_HIST = 16'h0081;
  localparam logic [15:0] ADDR_PARAM_BASE = 16'h0100;
  localparam logic [15:0] ADDR_COMMIT_NV = 16'h0900;
  localparam logic [15:0] ADDR_COMMIT_RAM = 16'h0910;

  // Link error detail bit positions.
  localparam int ERR_CRC_BIT = 0;
  localparam int ERR_LEN_BIT = 1;
  localparam int ERR_PARITY_BIT = 3;
  localparam int ERR_OVERRUN_BIT = 4;
  localparam int ERR_FRAMING_BIT = 5;
  localparam int ERR_TIMEOUT_BIT = 6;

  // Answer codes.
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_BAD_REG = 8'h02;
  localparam logic [7:0] EXC_BAD_DATA = 8'h21;
  localparam logic [7:0] EXC_WRITE_MODE = 8'h22;
  localparam logic [7:0] EXC_UNDERVOLT = 8'h23;

  localparam logic [15:0] COMMIT_VALUE = 16'h0000;

  // Fault code groups.
  localparam logic [7:0] FAULT_MAIN_LO = 8'h01;
  localparam logic [7:0] FAULT_MAIN_HI = 8'h2a;
  localparam logic [7:0] FAULT_SELF_LO = 8'h37;
  localparam logic [7:0] FAULT_SELF_HI = 8'h39;
  localparam logic [7:0] FAULT_BOARD_LO = 8'h83;
  localparam logic [7:0] FAULT_BOARD_HI = 8'h94;

  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [6:0] RESET_LINK_ERR = 7'h00;
endpackage : dsc_pkg

// ==== tb/dsc_host_model.sv ====
`timescale 1ns/100ps
module dsc_host_model (
  // Clock
  input wire logic i_clk,
  // Request toward the device
  output logic o_valid,
  output logic o_write,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata
);
  int nv_commits = 0;
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_addr = 16'h0;
    o_wdata = 16'h0;
  end
  // Released lines show the inverse so a stale value is never trusted.
  task automatic send(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_write = wr;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
    o_write = ~wr;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : send
  task automatic commit(input logic [15:0] a);
    if (a == dsc_pkg::ADDR_COMMIT_NV) nv_commits++;
    send(1'b1, a, dsc_pkg::COMMIT_VALUE);
  endtask : commit
endmodule : dsc_host_model

// ==== tb/dsc_status_commit_properties.sv ====
`timescale 1ns/100ps
module dsc_status_commit_properties #(
  parameter int PARAM_N = 16
) (
  // Clock, reset and request
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [15:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  // Conditions
  input wire logic [8:0] i_drive_cond,
  input wire logic i_freq_ref_from_link,
  input wire logic i_run_cmd_from_link,
  input wire logic i_overtorque,
  input wire logic i_ref_lost,
  input wire logic i_restarting,
  input wire logic i_any_fault,
  input wire logic i_link_timeout,
  input wire logic [2:0] i_relay_closed,
  // Answers
  input wire logic o_rsp_valid,
  input wire logic [15:0] o_rsp_rdata,
  input wire logic [7:0] o_rsp_exc,
  input wire logic [PARAM_N*16-1:0] o_param_work,
  input wire logic o_nvm_store,
  input wire logic [15:0] o_ref_a
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic rd;
  logic wr;
  logic ok_cm;
  logic cm_nv;
  logic cm_any;
  assign rd = i_req_valid && !i_req_write;
  assign wr = i_req_valid && i_req_write;
  assign cm_any = i_req_addr == dsc_pkg::ADDR_COMMIT_NV || i_req_addr == dsc_pkg::ADDR_COMMIT_RAM;
  assign ok_cm = wr && cm_any && i_req_wdata == 16'h0 && !i_drive_cond[0] && !i_drive_cond[7];
  assign cm_nv = ok_cm && i_req_addr == dsc_pkg::ADDR_COMMIT_NV;
  a_state_low_bits: assert property (
    rd && i_req_addr == dsc_pkg::ADDR_DRIVE_STATE |=> o_rsp_valid && o_rsp_rdata[10:0] ==
    {~$past(i_run_cmd_from_link), ~$past(i_freq_ref_from_link), $past(i_drive_cond)})
    else $error("state word low bits wrong");
  a_state_flag_bits: assert property (
    rd && i_req_addr == dsc_pkg::ADDR_DRIVE_STATE |=> o_rsp_rdata[15:11] == $past({i_link_timeout,
    i_any_fault | i_link_timeout, i_restarting, i_ref_lost, i_overtorque}))
    else $error("state word flag bits wrong");
  a_relay_word: assert property (
    rd && i_req_addr == dsc_pkg::ADDR_RELAY_STATE
    |=> o_rsp_rdata == {13'h0, $past(i_relay_closed)})
    else $error("relay word wrong");
  a_commit_bad_data: assert property (
    wr && cm_any && i_req_wdata != 16'h0 |=> o_rsp_exc == dsc_pkg::EXC_BAD_DATA)
    else $error("nonzero commit not refused");
  a_nv_commit_store: assert property (
    cm_nv |=> o_nvm_store && o_rsp_exc == dsc_pkg::EXC_NONE)
    else $error("nonvolatile commit did not store");
  a_store_only_nv: assert property (
    o_nvm_store |-> $past(cm_nv))
    else $error("store without nonvolatile commit");
  a_param_hold: assert property (
    !ok_cm |=> $stable(o_param_work))
    else $error("working copy changed without commit");
  a_commit_read: assert property (
    rd && cm_any |=> o_rsp_exc == dsc_pkg::EXC_BAD_REG && o_rsp_rdata == 16'h0)
    else $error("commit register read not refused");
  a_ref_direct: assert property (
    wr && i_req_addr == dsc_pkg::ADDR_REF_A |=> o_ref_a == $past(i_req_wdata))
    else $error("reference not applied");
  a_undervolt_commit: assert property (
    wr && cm_any && i_req_wdata == 16'h0 && !i_drive_cond[0] && i_drive_cond[7]
    |=> o_rsp_exc == dsc_pkg::EXC_UNDERVOLT && !o_nvm_store)
    else $error("commit in undervoltage not refused");
  a_store_pulse: assert property (
    o_nvm_store |=> !o_nvm_store)
    else $error("store strobe longer than one cycle");
endmodule : dsc_status_commit_properties
bind dsc_status_commit dsc_status_commit_properties #(.PARAM_N(PARAM_N)) u_props (
  .i_clk(i_clk), .i_srst(i_srst), .i_req_valid(i_req_valid), .i_req_write(i_req_write),
  .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .i_drive_cond(i_drive_cond),
  .i_freq_ref_from_link(i_freq_ref_from_link), .i_run_cmd_from_link(i_run_cmd_from_link),
  .i_overtorque(i_overtorque), .i_ref_lost(i_ref_lost), .i_restarting(i_restarting),
  .i_any_fault(i_any_fault), .i_link_timeout(i_link_timeout), .i_relay_closed(i_relay_closed),
  .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .o_rsp_exc(o_rsp_exc),
  .o_param_work(o_param_work), .o_nvm_store(o_nvm_store), .o_ref_a(o_ref_a));

// ==== tb/tb_drive_status_and_commit_registers.sv ====
`timescale 1ns/100ps
module tb_drive_status_and_commit_registers;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_req_valid;
  logic i_req_write;
  logic [15:0] i_req_addr;
  logic [15:0] i_req_wdata;
  logic [8:0] i_drive_cond = 9'h0;
  logic [4:0] flg = 5'h0;
  logic [1:0] src = 2'h0;
  logic [2:0] rel = 3'h0;
  logic [6:0] err = 7'h0;
  logic fv = 1'b0;
  logic [7:0] fc = 8'h0;
  logic [15:0] mon [7] = '{default: 16'h0};
  logic [15:0] mad [7] = '{16'h0031, 16'h0032, 16'h0033, 16'h003b, 16'h003c, 16'h003e, 16'h003f};
  logic [15:0] bad [6] = '{16'h002e, 16'h0030, 16'h0034, 16'h003a, 16'h0900, 16'h0910};
  logic [7:0] fcs [9] = '{8'h01, 8'h2a, 8'h2b, 8'h37, 8'h39, 8'h36, 8'h83, 8'h94, 8'h95};
  logic [7:0] hst [4] = '{8'h94, 8'h83, 8'h39, 8'h37};
  logic o_rsp_valid;
  logic [15:0] o_rsp_rdata;
  logic [7:0] o_rsp_exc;
  logic [255:0] o_param_work;
  logic o_nvm_store;
  logic [15:0] o_ref_a;
  logic [15:0] o_ref_b;
  logic [15:0] pv;
  logic [15:0] sw;
  logic [7:0] cur;
  logic [5:0] le;
  logic [5:0] e;
  logic [23:0] exp_q [$];
  int num_errors = 0;
  int checks = 0;
  always #12.5 i_clk = ~i_clk;
  dsc_status_commit dut (.i_clk(i_clk), .i_srst(i_srst), .i_req_valid(i_req_valid),
    .i_req_write(i_req_write), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
    .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .o_rsp_exc(o_rsp_exc),
    .i_drive_cond(i_drive_cond), .i_freq_ref_from_link(src[0]), .i_run_cmd_from_link(src[1]),
    .i_overtorque(flg[0]), .i_ref_lost(flg[1]), .i_restarting(flg[2]), .i_any_fault(flg[3]),
    .i_link_timeout(flg[4]), .i_relay_closed(rel), .i_dc_bus(mon[0]), .i_torque(mon[1]),
    .i_power(mon[2]), .i_cpu_fw(mon[3]), .i_flash_fw(mon[4]), .i_power_rating(mon[5]),
    .i_ctrl_method(mon[6]), .i_err_crc(err[0]), .i_err_len(err[1]), .i_err_parity(err[2]),
    .i_err_overrun(err[3]), .i_err_framing(err[4]), .i_err_timeout(err[5]),
    .i_err_reset(err[6]), .i_fault_valid(fv), .i_fault_code(fc), .o_param_work(o_param_work),
    .o_nvm_store(o_nvm_store), .o_ref_a(o_ref_a), .o_ref_b(o_ref_b));
  dsc_host_model host (.i_clk(i_clk), .o_valid(i_req_valid), .o_write(i_req_write),
    .o_addr(i_req_addr), .o_wdata(i_req_wdata));
  task automatic chk(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic op(input logic w, input logic [15:0] a, d, input logic [7:0] x,
                    input logic [15:0] r);
    exp_q.push_back({x, r});
    host.send(w, a, d);
  endtask : op
  task automatic cm(input logic [15:0] a);
    exp_q.push_back({dsc_pkg::EXC_NONE, 16'h0});
    host.commit(a);
  endtask : cm
  task automatic strobe(ref logic [6:0] s, input logic [6:0] v);
    @(posedge i_clk);
    #1;
    s = v;
    @(posedge i_clk);
    #1;
    s = 7'h0;
  endtask : strobe
  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  always @(negedge i_clk) begin
    if (o_rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "answer without request");
      else chk({o_rsp_exc, o_rsp_rdata} === exp_q.pop_front(), "answer value");
    end
  end
  initial begin
    #(25 * 4000);
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(32'h73b4));
    repeat (3) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    chk(o_param_work === 256'h0 && o_ref_a === 16'h0, "reset outputs");
    for (int n = 0; n < 8; n++) begin
      i_drive_cond = 9'($urandom());
      flg = 5'($urandom());
      src = 2'($urandom());
      rel = 3'($urandom());
      foreach (mon[i]) mon[i] = 16'($urandom());
      sw = {flg[4], flg[3] | flg[4], flg[2:0], ~src, i_drive_cond};
      op(0, 16'h002c, 0, 8'h00, sw);
      op(0, 16'h002d, 0, 8'h00, {13'h0, rel});
      op(0, mad[n % 7], 0, 8'h00, mon[n % 7]);
    end
    $display("test status words done");
    foreach (bad[i]) op(0, bad[i], 0, dsc_pkg::EXC_BAD_REG, 16'h0);
    op(1, 16'h002c, 0, dsc_pkg::EXC_WRITE_MODE, 16'h0);
    op(1, 16'h002f, 0, dsc_pkg::EXC_BAD_REG, 16'h0);
    $display("test refused reads done");
    le = 6'h0;
    repeat (2) begin
      e = 6'($urandom());
      le = le | e;
      strobe(err, {1'b0, e});
    end
    op(0, 16'h003d, 0, 8'h00, {9'h0, le[5:2], 1'b0, le[1:0]});
    strobe(err, 7'h40);
    op(0, 16'h003d, 0, 8'h00, 16'h0);
    strobe(err, 7'h41);
    op(0, 16'h003d, 0, 8'h00, 16'h0001);
    $display("test link errors done");
    i_drive_cond = 9'h0;
    pv = 16'($urandom());
    op(1, 16'h0100, pv, 8'h00, 16'h0);
    op(0, 16'h0100, 0, 8'h00, pv);
    chk(o_param_work === 256'h0, "applied before commit");
    op(1, 16'h0910, 16'h0001, dsc_pkg::EXC_BAD_DATA, 16'h0);
    i_drive_cond = 9'h001;
    op(1, 16'h0900, 16'h0, dsc_pkg::EXC_WRITE_MODE, 16'h0);
    op(1, 16'h0101, pv, dsc_pkg::EXC_WRITE_MODE, 16'h0);
    op(0, 16'h0101, 0, 8'h00, 16'h0);
    i_drive_cond = 9'h080;
    op(1, 16'h0910, 16'h0, dsc_pkg::EXC_UNDERVOLT, 16'h0);
    i_drive_cond = 9'h0;
    chk(o_param_work === 256'h0, "refused commit applied");
    cm(dsc_pkg::ADDR_COMMIT_RAM);
    chk(o_param_work[15:0] === pv && o_nvm_store === 1'b0, "volatile commit");
    op(1, 16'h010f, ~pv, 8'h00, 16'h0);
    cm(dsc_pkg::ADDR_COMMIT_NV);
    chk(o_param_work[255:240] === ~pv && o_nvm_store === 1'b1, "nonvolatile commit");
    $display("test commits done");
    op(1, 16'h0001, pv, 8'h00, 16'h0);
    chk(o_ref_a === pv, "reference a");
    op(1, 16'h0002, ~pv, 8'h00, 16'h0);
    op(0, 16'h0002, 0, 8'h00, ~pv);
    chk(o_ref_b === ~pv && o_nvm_store === 1'b0, "reference b");
    $display("test references done");
    cur = 8'h0;
    foreach (fcs[i]) begin
      @(posedge i_clk);
      #1;
      fv = 1'b1;
      fc = fcs[i];
      @(posedge i_clk);
      #1;
      fv = 1'b0;
      if (i != 2 && i != 5 && i != 8) cur = fcs[i];
      op(0, 16'h0080, 0, 8'h00, {8'h0, cur});
    end
    foreach (hst[i]) op(0, 16'h0081 + 16'(i), 0, 8'h00, {8'h0, hst[i]});
    op(1, 16'h0081, 0, dsc_pkg::EXC_WRITE_MODE, 16'h0);
    op(0, 16'h0085, 0, dsc_pkg::EXC_BAD_REG, 16'h0);
    $display("test faults done");
    repeat (3) @(posedge i_clk);
    chk(exp_q.size() == 0, "missing answers");
    chk(host.nv_commits == 1, "nonvolatile commit count");
    results();
  end
endmodule : tb_drive_status_and_commit_registers

// ==== verilog/dsc_status_commit.sv ====
`timescale 1ns/100ps
// Operation
// - State word bits 0..8 report run, zero speed, agreements, detections, startup, undervoltage, baseblock.
// - Bits 9 and A read 0 when reference or run comes from link.
// - Bits B..F flag overtorque, reference lost, restart, any error, link timeout.
// - Relay word bits 0..2 show contacts closed as 1; upper bits zero.
// - Link error bits latch CRC, length, parity, overrun, framing, timeout until reset.
// - Parameter writes sit in a pending area until committed.
// - Writing 0 to a commit register runs that register's commit unless running (bit 0) or in undervoltage (bit 7).
// - Nonvolatile commit stores to nonvolatile memory and refreshes working copy.
// - Volatile commit refreshes working copy only, nonvolatile memory untouched.
// - Reading a commit register answers error code 02H.
// - Reference words A and B take effect directly without commit.
// - Fault codes are 8-bit values from fixed groups of the code table.
// - Host reads current fault code and a history of the last HIST_N codes, current code first.
// - Unknown or unused register addresses answer invalid register code.
module dsc_status_commit #(
  parameter int PARAM_N = 16,
  parameter int HIST_N = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Register request from the frame decoder
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [15:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  // Register answer
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_rdata,
  output logic [7:0] o_rsp_exc,
  // Drive condition inputs
  input wire logic [8:0] i_drive_cond,
  input wire logic i_freq_ref_from_link,
  input wire logic i_run_cmd_from_link,
  input wire logic i_overtorque,
  input wire logic i_ref_lost,
  input wire logic i_restarting,
  input wire logic i_any_fault,
  input wire logic i_link_timeout,
  input wire logic [2:0] i_relay_closed,
  // Monitored quantities
  input wire logic [15:0] i_dc_bus,
  input wire logic [15:0] i_torque,
  input wire logic [15:0] i_power,
  input wire logic [15:0] i_cpu_fw,
  input wire logic [15:0] i_flash_fw,
  input wire logic [15:0] i_power_rating,
  input wire logic [15:0] i_ctrl_method,
  // Link error events, one-cycle pulses
  input wire logic i_err_crc,
  input wire logic i_err_len,
  input wire logic i_err_parity,
  input wire logic i_err_overrun,
  input wire logic i_err_framing,
  input wire logic i_err_timeout,
  input wire logic i_err_reset,
  // Fault reports
  input wire logic i_fault_valid,
  input wire logic [7:0] i_fault_code,
  // Parameter working copy and nonvolatile store strobe
  output logic [PARAM_N*16-1:0] o_param_work,
  output logic o_nvm_store,
  // Directly applied reference words
  output logic [15:0] o_ref_a,
  output logic [15:0] o_ref_b
);

  localparam int PIDX_W = (PARAM_N > 1) ? $clog2(PARAM_N) : 1;
  localparam int HIDX_W = (HIST_N > 1) ? $clog2(HIST_N) : 1;

  logic [15:0] pending_ff [PARAM_N];
  logic [PARAM_N*16-1:0] work_ff;
  logic [6:0] link_err_ff;
  logic [7:0] fault_now_ff;
  logic [7:0] hist_ff [HIST_N];
  logic rsp_valid_ff;
  logic [15:0] rsp_rdata_ff;
  logic [7:0] rsp_exc_ff;
  logic nvm_store_ff;
  logic [15:0] ref_a_ff;
  logic [15:0] ref_b_ff;

  logic [15:0] nxt_rdata;
  logic [7:0] nxt_exc;
  logic [15:0] state_word;
  logic [15:0] param_off;
  logic is_param;
  logic is_hist;
  logic [15:0] hist_off;
  logic do_commit_nv;
  logic do_commit_ram;
  logic do_param_wr;
  logic do_ref_a;
  logic do_ref_b;
  logic fault_main;
  logic fault_self;
  logic fault_board;
  logic fault_ok;

  always_comb begin
    state_word = {i_link_timeout, i_any_fault | i_link_timeout, i_restarting, i_ref_lost,
                  i_overtorque, ~i_run_cmd_from_link, ~i_freq_ref_from_link, i_drive_cond};
  end

  always_comb begin
    param_off = i_req_addr - dsc_pkg::ADDR_PARAM_BASE;
    is_param = (i_req_addr >= dsc_pkg::ADDR_PARAM_BASE) && (param_off < 16'(PARAM_N));
    hist_off = i_req_addr - dsc_pkg::ADDR_FAULT_HIST;
    is_hist = (i_req_addr >= dsc_pkg::ADDR_FAULT_HIST) && (hist_off < 16'(HIST_N));
  end

  always_comb begin
    fault_main = (i_fault_code >= dsc_pkg::FAULT_MAIN_LO)
              && (i_fault_code <= dsc_pkg::FAULT_MAIN_HI);
    fault_self = (i_fault_code >= dsc_pkg::FAULT_SELF_LO)
              && (i_fault_code <= dsc_pkg::FAULT_SELF_HI);
    fault_board = (i_fault_code >= dsc_pkg::FAULT_BOARD_LO)
               && (i_fault_code <= dsc_pkg::FAULT_BOARD_HI);
    // Codes outside the table are dropped, so the trace only holds decodable values.
    fault_ok = fault_main || fault_self || fault_board;
  end

  // Decode: read data, answer code and write actions for this request.
  always_comb begin
    nxt_rdata = dsc_pkg::RESET_WORD;
    nxt_exc = dsc_pkg::EXC_NONE;
    do_commit_nv = 1'b0;
    do_commit_ram = 1'b0;
    do_param_wr = 1'b0;
    do_ref_a = 1'b0;
    do_ref_b = 1'b0;
    if (i_req_write) begin
      if (i_req_addr == dsc_pkg::ADDR_COMMIT_NV || i_req_addr == dsc_pkg::ADDR_COMMIT_RAM) begin
        // A commit while running or in undervoltage would corrupt live settings.
        if (i_req_wdata != dsc_pkg::COMMIT_VALUE) begin
          nxt_exc = dsc_pkg::EXC_BAD_DATA;
        end else if (i_drive_cond[0]) begin
          nxt_exc = dsc_pkg::EXC_WRITE_MODE;
        end else if (i_drive_cond[7]) begin
          nxt_exc = dsc_pkg::EXC_UNDERVOLT;
        end else begin
          do_commit_nv = (i_req_addr == dsc_pkg::ADDR_COMMIT_NV);
          do_commit_ram = (i_req_addr == dsc_pkg::ADDR_COMMIT_RAM);
        end
      end else if (is_param) begin
        if (i_drive_cond[0]) begin
          nxt_exc = dsc_pkg::EXC_WRITE_MODE;
        end else begin
          do_param_wr = 1'b1;
        end
      end else if (i_req_addr == dsc_pkg::ADDR_REF_A) begin
        do_ref_a = 1'b1;
      end else if (i_req_addr == dsc_pkg::ADDR_REF_B) begin
        do_ref_b = 1'b1;
      end else begin
        unique case (i_req_addr)
          dsc_pkg::ADDR_DRIVE_STATE, dsc_pkg::ADDR_RELAY_STATE, dsc_pkg::ADDR_DC_BUS,
          dsc_pkg::ADDR_TORQUE, dsc_pkg::ADDR_POWER, dsc_pkg::ADDR_CPU_FW,
          dsc_pkg::ADDR_FLASH_FW, dsc_pkg::ADDR_LINK_ERR, dsc_pkg::ADDR_POWER_RATING,
          dsc_pkg::ADDR_CTRL_METHOD, dsc_pkg::ADDR_FAULT_NOW: begin
            nxt_exc = dsc_pkg::EXC_WRITE_MODE;
          end
          default: begin
            nxt_exc = is_hist ? dsc_pkg::EXC_WRITE_MODE : dsc_pkg::EXC_BAD_REG;
          end
        endcase
      end
    end else begin
      if (is_param) begin
        nxt_rdata = pending_ff[param_off[PIDX_W-1:0]];
      end else if (is_hist) begin
        nxt_rdata = {8'h00, hist_ff[hist_off[HIDX_W-1:0]]};
      end else begin
        unique case (i_req_addr)
          dsc_pkg::ADDR_REF_A: nxt_rdata = ref_a_ff;
          dsc_pkg::ADDR_REF_B: nxt_rdata = ref_b_ff;
          dsc_pkg::ADDR_DRIVE_STATE: nxt_rdata = state_word;
          dsc_pkg::ADDR_RELAY_STATE: nxt_rdata = {13'h0000, i_relay_closed};
          dsc_pkg::ADDR_DC_BUS: nxt_rdata = i_dc_bus;
          dsc_pkg::ADDR_TORQUE: nxt_rdata = i_torque;
          dsc_pkg::ADDR_POWER: nxt_rdata = i_power;
          dsc_pkg::ADDR_CPU_FW: nxt_rdata = i_cpu_fw;
          dsc_pkg::ADDR_FLASH_FW: nxt_rdata = i_flash_fw;
          dsc_pkg::ADDR_LINK_ERR: nxt_rdata = {9'h000, link_err_ff};
          dsc_pkg::ADDR_POWER_RATING: nxt_rdata = i_power_rating;
          dsc_pkg::ADDR_CTRL_METHOD: nxt_rdata = i_ctrl_method;
          dsc_pkg::ADDR_FAULT_NOW: nxt_rdata = {8'h00, fault_now_ff};
          dsc_pkg::ADDR_COMMIT_NV, dsc_pkg::ADDR_COMMIT_RAM: nxt_exc = dsc_pkg::EXC_BAD_REG;
          default: nxt_exc = dsc_pkg::EXC_BAD_REG;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= dsc_pkg::RESET_WORD;
      rsp_exc_ff <= dsc_pkg::EXC_NONE;
    end else begin
      rsp_valid_ff <= i_req_valid;
      rsp_rdata_ff <= i_req_valid ? nxt_rdata : dsc_pkg::RESET_WORD;
      rsp_exc_ff <= i_req_valid ? nxt_exc : dsc_pkg::EXC_NONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i < PARAM_N; i++) begin
        pending_ff[i] <= dsc_pkg::RESET_WORD;
      end
    end else if (i_req_valid && do_param_wr) begin
      pending_ff[param_off[PIDX_W-1:0]] <= i_req_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      work_ff <= '0;
    end else if (i_req_valid && (do_commit_nv || do_commit_ram)) begin
      for (int i = 0; i < PARAM_N; i++) begin
        work_ff[i*16 +: 16] <= pending_ff[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      nvm_store_ff <= 1'b0;
    end else begin
      nvm_store_ff <= i_req_valid && do_commit_nv;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ref_a_ff <= dsc_pkg::RESET_WORD;
      ref_b_ff <= dsc_pkg::RESET_WORD;
    end else begin
      if (i_req_valid && do_ref_a) begin
        ref_a_ff <= i_req_wdata;
      end
      if (i_req_valid && do_ref_b) begin
        ref_b_ff <= i_req_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      link_err_ff <= dsc_pkg::RESET_LINK_ERR;
    end else begin
      // An error seen in the same cycle as the reset is kept, not lost.
      link_err_ff <= (i_err_reset ? dsc_pkg::RESET_LINK_ERR : link_err_ff)
                   | (7'(i_err_crc) << dsc_pkg::ERR_CRC_BIT)
                   | (7'(i_err_len) << dsc_pkg::ERR_LEN_BIT)
                   | (7'(i_err_parity) << dsc_pkg::ERR_PARITY_BIT)
                   | (7'(i_err_overrun) << dsc_pkg::ERR_OVERRUN_BIT)
                   | (7'(i_err_framing) << dsc_pkg::ERR_FRAMING_BIT)
                   | (7'(i_err_timeout) << dsc_pkg::ERR_TIMEOUT_BIT);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fault_now_ff <= 8'h00;
      for (int i = 0; i < HIST_N; i++) begin
        hist_ff[i] <= 8'h00;
      end
    end else if (i_fault_valid && fault_ok) begin
      fault_now_ff <= i_fault_code;
      hist_ff[0] <= i_fault_code;
      for (int i = 1; i < HIST_N; i++) begin
        hist_ff[i] <= hist_ff[i-1];
      end
    end
  end

  assign o_rsp_valid = rsp_valid_ff;
  assign o_rsp_rdata = rsp_rdata_ff;
  assign o_rsp_exc = rsp_exc_ff;
  assign o_param_work = work_ff;
  assign o_nvm_store = nvm_store_ff;
  assign o_ref_a = ref_a_ff;
  assign o_ref_b = ref_b_ff;

endmodule : dsc_status_commit
